// *** rtl/tac_consts.svh ***
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH

// Fixed upper five bits of the slave address.
`define TAC_ADDR_FIXED     5'h12
// Upper five bits of a high-speed master code.
`define TAC_MCODE_PREFIX   5'h01
// Function code of the setup command.
`define TAC_SETUP_CODE     4'hb
// Value sent when the master asks for bytes past the second.
`define TAC_INVALID_BYTE   8'hff
// Bit counter value of the last data bit and of the acknowledge bit.
`define TAC_BIT_LAST       4'h7
`define TAC_BIT_ACK        4'h8
// Bit counter value at which the last function bit has been taken.
`define TAC_BIT_FUNC_LAST  4'h3
// Bit counter value after a start or stop; the SCL fall that ends a start
// wraps it to zero, so that this fall is not counted as a data bit.
`define TAC_BIT_IDLE       4'hf
// Reset values.
`define TAC_SETUP_RESET    4'h0
`define TAC_CMD_RESET      8'h00

`endif

// *** rtl/tac_pkg.sv ***
package tac_pkg;

  typedef enum logic [1:0] {
    PH_ADDR,
    PH_WRITE,
    PH_READ,
    PH_IGNORE
  } tac_phase_e;

  typedef struct packed {
    logic [3:0] function_select;
    logic [1:0] power_mode_bits;
    logic       res_8bit;
    logic       dont_care;
  } tac_cmd_s;

  typedef struct packed {
    logic [1:0] reserved;
    logic       filter_bypass;
    logic       pullup_90k;
  } tac_setup_s;

endpackage

// *** rtl/tac_i2c_port.sv ***
// Notes on behaviour
// - SDA falling with SCL high starts transfer.
// - SDA rising with SCL high stops transfer.
// - Drive SDA changes only while SCL low.
// - Eight data bits plus acknowledge per byte.
// - Never acknowledge or match a master code.
// - High speed: stretch SCL until result loaded.
// - High speed persists until a stop.
// - Address is 10010 plus two strap pins.
// - Straps sampled anew on every address byte.
// - Address latched on falling edge after direction.
// - Address bit zero: one read, zero write.
// - Acknowledge only a fully matching address byte.
// - Command upper nibble selects converter function.
// - Command bits three to two set power mode.
// - Command bit one selects resolution; bit zero ignored.
// - Setup bit one bypasses the averaging filter.
// - Setup bit zero selects the larger pull-up.
// - Setup bits static; only reset or a setup command changes them.
// - Only the first command byte is acknowledged.
// - Acquire from last function bit until start/stop.
// - Read returns high bits, then low bits padded.
// - Further acknowledged reads return all ones.
`timescale 1ns/1ps
`include "tac_consts.svh"
module tac_i2c_port #(
  parameter int RESULT_W = 12
) (
  input  wire logic                CLK_I,
  input  wire logic                RST_I,
  input  wire logic                SCL_I,
  input  wire logic                SDA_I,
  input  wire logic [1:0]          ADDR_STRAP_PINS_I,
  input  wire logic [RESULT_W-1:0] RESULT_I,
  input  wire logic                RESULT_VALID_I,
  output logic                     SDA_O,
  output logic                     SDA_OE_O,
  output logic                     SCL_O,
  output logic                     SCL_OE_O,
  output logic [3:0]               FUNCTION_SELECT_O,
  output logic [1:0]               POWER_MODE_BITS_O,
  output logic                     RES_8BIT_O,
  output logic                     FILTER_BYPASS_O,
  output logic                     PULLUP_90K_O,
  output logic                     CMD_STROBE_O,
  output logic                     ACQUIRE_O,
  output logic                     CONV_START_O,
  output logic                     HS_MODE_O
);

  if (RESULT_W != 12)
  begin : g_check
    $error("RESULT_W must be 12.");
  end

  function automatic logic func_ok(input logic [3:0] f);
    case (f)
      4'h0, 4'h2, 4'h4, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he, 4'hf:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  // System domain: pin synchronisers and bus condition detection.
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic frame_clr_reg, link_rst_reg;
  logic start_det, stop_det;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= SCL_I;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= SDA_I;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  assign start_det = scl_s3_reg && scl_s2_reg && sda_s3_reg && !sda_s2_reg;
  assign stop_det  = scl_s3_reg && scl_s2_reg && !sda_s3_reg && sda_s2_reg;

  // The bit engine is cleared at every start and stop; event toggles and strap stages only at reset.
  always_ff @(posedge CLK_I)
  begin
    link_rst_reg  <= RST_I;
    frame_clr_reg <= RST_I || start_det || stop_det;
  end

  // Link domain: bit engine clocked by SCL.
  tac_pkg::tac_phase_e phase_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg, tx_reg, cmd_byte_reg;
  logic [6:0] addr_reg;
  logic [1:0] strap_s1_reg, strap_s2_reg, rd_idx_reg;
  logic       mack_reg, sda_oe_reg, wr_done_reg, in_read_reg;
  logic       mcode_tog_reg, cmd_tog_reg, func_tog_reg;
  logic       addr_match, mcode_seen;
  logic [7:0] tx_next;
  logic [RESULT_W-1:0] result_reg;

  // Data is taken on the rising edge of SCL.
  always_ff @(posedge SCL_I or posedge frame_clr_reg)
  begin
    if (frame_clr_reg)
    begin
      sh_reg   <= 8'h00;
      mack_reg <= 1'b0;
    end
    else
    begin
      sh_reg <= {sh_reg[6:0], SDA_I};
      if (cnt_reg == `TAC_BIT_ACK)
        mack_reg <= !SDA_I;
    end
  end

  always_ff @(posedge SCL_I or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
    end
    else
    begin
      strap_s1_reg <= ADDR_STRAP_PINS_I;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  assign addr_match = (sh_reg[7:3] == `TAC_ADDR_FIXED) &&
                      (sh_reg[2:1] == strap_s2_reg);
  assign mcode_seen = (sh_reg[7:3] == `TAC_MCODE_PREFIX);

  always_comb
  begin
    if (rd_idx_reg == 2'h0)
      tx_next = result_reg[11:4];
    else if (rd_idx_reg == 2'h1)
      tx_next = {result_reg[3:0], 4'h0};
    else
      tx_next = `TAC_INVALID_BYTE;
  end

  // SDA is driven only from the falling edge of SCL.
  always_ff @(negedge SCL_I or posedge frame_clr_reg)
  begin
    if (frame_clr_reg)
    begin
      phase_reg   <= tac_pkg::PH_ADDR;
      cnt_reg     <= `TAC_BIT_IDLE;
      sda_oe_reg  <= 1'b0;
      tx_reg      <= 8'h00;
      rd_idx_reg  <= 2'h0;
      wr_done_reg <= 1'b0;
      in_read_reg <= 1'b0;
      addr_reg    <= 7'h00;
    end
    else
    begin
      cnt_reg <= (cnt_reg == `TAC_BIT_ACK) ? 4'h0 : cnt_reg + 4'h1;
      if (cnt_reg == `TAC_BIT_LAST)
      begin
        sda_oe_reg <= 1'b0;
        case (phase_reg)
          tac_pkg::PH_ADDR:
          begin
            addr_reg <= sh_reg[7:1];
            if (addr_match && !mcode_seen)
            begin
              sda_oe_reg  <= 1'b1;
              in_read_reg <= sh_reg[0];
              phase_reg   <= sh_reg[0] ? tac_pkg::PH_READ
                                       : tac_pkg::PH_WRITE;
            end
            else
              phase_reg <= tac_pkg::PH_IGNORE;
          end
          tac_pkg::PH_WRITE:
          begin
            sda_oe_reg  <= !wr_done_reg && func_ok(sh_reg[7:4]);
            wr_done_reg <= 1'b1;
          end
          default:
            sda_oe_reg <= 1'b0;
        endcase
      end
      else if (cnt_reg == `TAC_BIT_ACK)
      begin
        if (phase_reg == tac_pkg::PH_READ &&
            (rd_idx_reg == 2'h0 || mack_reg))
        begin
          tx_reg     <= tx_next;
          sda_oe_reg <= !tx_next[7];
          if (rd_idx_reg != 2'h2)
            rd_idx_reg <= rd_idx_reg + 2'h1;
        end
        else
        begin
          sda_oe_reg <= 1'b0;
          if (phase_reg == tac_pkg::PH_READ)
            phase_reg <= tac_pkg::PH_IGNORE;
        end
        in_read_reg <= 1'b0;
      end
      else if (phase_reg == tac_pkg::PH_READ)
      begin
        tx_reg     <= {tx_reg[6:0], 1'b0};
        sda_oe_reg <= !tx_reg[6];
      end
    end
  end

  // Events to the system domain, each as a toggle with stable data.
  always_ff @(negedge SCL_I or posedge link_rst_reg)
  begin
    if (link_rst_reg)
    begin
      mcode_tog_reg <= 1'b0;
      cmd_tog_reg   <= 1'b0;
      func_tog_reg  <= 1'b0;
      cmd_byte_reg  <= `TAC_CMD_RESET;
    end
    else
    begin
      if (phase_reg == tac_pkg::PH_ADDR && cnt_reg == `TAC_BIT_LAST &&
          mcode_seen)
        mcode_tog_reg <= !mcode_tog_reg;
      if (phase_reg == tac_pkg::PH_WRITE && !wr_done_reg &&
          cnt_reg == `TAC_BIT_FUNC_LAST && func_ok(sh_reg[3:0]))
        func_tog_reg <= !func_tog_reg;
      if (phase_reg == tac_pkg::PH_WRITE && !wr_done_reg &&
          cnt_reg == `TAC_BIT_LAST &&
          (func_ok(sh_reg[7:4]) || sh_reg[7:4] == `TAC_SETUP_CODE))
      begin
        cmd_byte_reg <= sh_reg;
        cmd_tog_reg  <= !cmd_tog_reg;
      end
    end
  end

  assign SDA_O    = 1'b0;
  assign SDA_OE_O = sda_oe_reg;
  assign SCL_O    = 1'b0;

  // System domain: event synchronisers and command state.
  logic [2:0] mcode_sync_reg, cmd_sync_reg, func_sync_reg;
  logic [1:0] read_sync_reg;
  logic       hs_reg, acq_reg, conv_reg, busy_reg, strobe_reg;
  logic       mcode_evt, cmd_evt, func_evt, is_setup;
  tac_pkg::tac_cmd_s   cmd_reg, cmd_in;
  tac_pkg::tac_setup_s setup_reg;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      mcode_sync_reg <= 3'h0;
      cmd_sync_reg   <= 3'h0;
      func_sync_reg  <= 3'h0;
      read_sync_reg  <= 2'h0;
    end
    else
    begin
      mcode_sync_reg <= {mcode_sync_reg[1:0], mcode_tog_reg};
      cmd_sync_reg   <= {cmd_sync_reg[1:0], cmd_tog_reg};
      func_sync_reg  <= {func_sync_reg[1:0], func_tog_reg};
      read_sync_reg  <= {read_sync_reg[0], in_read_reg};
    end
  end

  assign mcode_evt = mcode_sync_reg[2] ^ mcode_sync_reg[1];
  assign cmd_evt   = cmd_sync_reg[2] ^ cmd_sync_reg[1];
  assign func_evt  = func_sync_reg[2] ^ func_sync_reg[1];
  assign cmd_in    = cmd_byte_reg;
  assign is_setup  = cmd_in.function_select == `TAC_SETUP_CODE;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      hs_reg <= 1'b0;
    else if (mcode_evt)
      hs_reg <= 1'b1;
    else if (stop_det)
      hs_reg <= 1'b0;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      cmd_reg    <= `TAC_CMD_RESET;
      setup_reg  <= `TAC_SETUP_RESET;
      strobe_reg <= 1'b0;
    end
    else
    begin
      strobe_reg <= cmd_evt;
      if (cmd_evt && is_setup)
        setup_reg <= cmd_in[3:0];
      else if (cmd_evt)
        cmd_reg <= cmd_in;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      acq_reg  <= 1'b0;
      conv_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      conv_reg <= acq_reg && (start_det || stop_det);
      if (func_evt)
        acq_reg <= 1'b1;
      else if (start_det || stop_det)
        acq_reg <= 1'b0;
      if (conv_reg)
        busy_reg <= 1'b1;
      else if (RESULT_VALID_I)
        busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      result_reg <= '0;
    else if (RESULT_VALID_I)
      result_reg <= RESULT_I;
  end

  assign SCL_OE_O = hs_reg && read_sync_reg[1] && busy_reg;
  assign FUNCTION_SELECT_O = cmd_reg.function_select;
  assign POWER_MODE_BITS_O = cmd_reg.power_mode_bits;
  assign RES_8BIT_O        = cmd_reg.res_8bit;
  assign FILTER_BYPASS_O   = setup_reg.filter_bypass;
  assign PULLUP_90K_O      = setup_reg.pullup_90k;
  assign CMD_STROBE_O      = strobe_reg;
  assign ACQUIRE_O         = acq_reg;
  assign CONV_START_O      = conv_reg;
  assign HS_MODE_O         = hs_reg;

  sequence s_sda_fall_scl_high;
    scl_s3_reg && scl_s2_reg && sda_s3_reg && !sda_s2_reg;
  endsequence

  sequence s_frame_end;
    start_det || stop_det;
  endsequence

  a_start_clears_link: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_sda_fall_scl_high |=> frame_clr_reg)
    else $error("Start did not clear the link logic.");

  a_stop_ends_hs: assert property (@(posedge CLK_I) disable iff (RST_I)
    stop_det && !mcode_evt |=> !hs_reg)
    else $error("High-speed mode survived a stop.");

  a_hs_persists: assert property (@(posedge CLK_I) disable iff (RST_I)
    hs_reg && !stop_det |=> hs_reg)
    else $error("High-speed mode dropped without a stop.");

  a_setup_static: assert property (@(posedge CLK_I) disable iff (RST_I)
    cmd_evt && !is_setup |=> $stable(setup_reg))
    else $error("Setup bits changed on another command.");

  a_setup_loads: assert property (@(posedge CLK_I) disable iff (RST_I)
    cmd_evt && is_setup |=> setup_reg == $past(cmd_byte_reg[3:0]))
    else $error("Setup bits not taken from the setup command.");

  a_conv_follows_acq: assert property (@(posedge CLK_I) disable iff (RST_I)
    acq_reg && !func_evt ##0 s_frame_end |=> conv_reg && !acq_reg ##1 !conv_reg)
    else $error("Conversion did not follow the acquisition.");

  a_stretch_hs_only: assert property (@(posedge CLK_I) disable iff (RST_I)
    SCL_OE_O |-> hs_reg && busy_reg)
    else $error("SCL held low outside high-speed mode.");

  a_stretch_release: assert property (@(posedge CLK_I) disable iff (RST_I)
    SCL_OE_O && RESULT_VALID_I |=> !SCL_OE_O)
    else $error("SCL still held after the result was loaded.");

  a_mcode_no_ack: assert property (@(negedge SCL_I) disable iff (frame_clr_reg)
    phase_reg == tac_pkg::PH_ADDR && cnt_reg == `TAC_BIT_LAST && mcode_seen
    |=> !sda_oe_reg && phase_reg == tac_pkg::PH_IGNORE)
    else $error("Master code was acknowledged.");

  a_addr_ack: assert property (@(negedge SCL_I) disable iff (frame_clr_reg)
    phase_reg == tac_pkg::PH_ADDR && cnt_reg == `TAC_BIT_LAST &&
    addr_match |=> sda_oe_reg ##1 !sda_oe_reg || phase_reg == tac_pkg::PH_READ)
    else $error("Matching address not acknowledged.");

  a_extra_cmd_nack: assert property (@(negedge SCL_I) disable iff (frame_clr_reg)
    phase_reg == tac_pkg::PH_WRITE && wr_done_reg &&
    cnt_reg == `TAC_BIT_LAST |=> !sda_oe_reg)
    else $error("Extra command byte was acknowledged.");

endmodule

// *** testbench/tac_host_model.sv ***
`timescale 1ns/1ps
module tac_host_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_oe_o,
  output logic      sda_oe_o,
  output logic      timeout_o
);
  localparam time TQ = 100ns;
  initial
  begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    timeout_o = 1'b0;
  end
  // Releases SCL and waits while a slave holds it low.
  task automatic scl_rise();
    int n;
    scl_oe_o = 1'b0;
    n = 0;
    while (scl_i !== 1'b1 && n < 2000)
    begin
      #10ns;
      n++;
    end
    if (n >= 2000)
      timeout_o = 1'b1;
    #TQ;
  endtask
  task automatic start();
    sda_oe_o = 1'b0;
    #TQ;
    scl_rise();
    sda_oe_o = 1'b1;
    #(2*TQ);
    scl_oe_o = 1'b1;
    #TQ;
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    #TQ;
    scl_rise();
    sda_oe_o = 1'b0;
    #(2*TQ);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    sda_oe_o = ~b;
    #TQ;
    scl_rise();
    r = sda_i;
    scl_oe_o = 1'b1;
    #TQ;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(~ack, r);
  endtask
endmodule

// *** testbench/tac_i2c_port_test.sv ***
`timescale 1ns/1ps
module tac_i2c_port_test;
  logic        clk;
  logic        rst;
  logic        scl;
  logic        sda;
  logic [1:0]  strap;
  logic [11:0] result;
  logic        rvalid;
  logic        sda_oe;
  logic        scl_oe;
  logic        m_scl;
  logic        m_sda;
  logic        hang;
  logic [3:0]  fsel;
  logic [1:0]  pmode;
  logic        res8;
  logic        bypass;
  logic        pull90;
  logic        acq;
  logic        conv;
  logic        hs;
  logic        strobe;
  logic        stretched;
  logic        aa;
  logic        ac;
  logic        ok;
  logic [3:0]  code;
  logic [3:0]  fe;
  logic [1:0]  pe;
  logic        re;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic        sda_o;
  logic        scl_o;
  int          convs;
  int          c0;
  int          strobes;
  int          s0;
  int          busy;
  int          clen;
  int          bad_count;
  int          checks;
  assign scl = ~(scl_oe | m_scl);
  assign sda = ~(sda_oe | m_sda);
  tac_i2c_port tac_i2c_port_i (
    .CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .ADDR_STRAP_PINS_I(strap), .RESULT_I(result),
    .RESULT_VALID_I(rvalid), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .SCL_O(scl_o),
    .SCL_OE_O(scl_oe), .FUNCTION_SELECT_O(fsel),
    .POWER_MODE_BITS_O(pmode), .RES_8BIT_O(res8),
    .FILTER_BYPASS_O(bypass), .PULLUP_90K_O(pull90),
    .CMD_STROBE_O(strobe), .ACQUIRE_O(acq), .CONV_START_O(conv),
    .HS_MODE_O(hs)
  );
  tac_host_model tac_host_model_i (
    .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl), .sda_oe_o(m_sda),
    .timeout_o(hang)
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Converter stand-in: a result arrives clen cycles after a start.
  always @(posedge clk)
  begin
    rvalid <= #1 (busy == 1 && conv !== 1'b1);
    if (scl_oe === 1'b1)
      stretched <= #1 1'b1;
    if (strobe === 1'b1)
      strobes <= #1 strobes + 1;
    if (conv === 1'b1)
    begin
      convs <= #1 convs + 1;
      busy <= #1 clen;
    end
    else if (busy != 0)
      busy <= #1 busy - 1;
  end
  always @(posedge hang)
  begin
    bad_count++;
    finish_test();
  end
  task automatic chk(input string name, input logic [11:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] c);
    tac_host_model_i.start();
    tac_host_model_i.send_byte({5'h12, strap, 1'b0}, aa);
    tac_host_model_i.send_byte(c, ac);
  endtask
  task automatic rd();
    tac_host_model_i.start();
    tac_host_model_i.send_byte({5'h12, strap, 1'b1}, aa);
    tac_host_model_i.recv_byte(1'b1, b0);
    tac_host_model_i.recv_byte(1'b1, b1);
    tac_host_model_i.recv_byte(1'b0, b2);
  endtask
  task automatic stop_wait();
    tac_host_model_i.stop();
    repeat (8) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    strap = 2'h0;
    result = 12'ha5c;
    rvalid = 1'b0;
    stretched = 1'b0;
    convs = 0;
    strobes = 0;
    busy = 0;
    clen = 20;
    bad_count = 0;
    checks = 0;
    fe = 4'h0;
    pe = 2'h0;
    re = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    chk("bypass", bypass, 1'b0);
    chk("pull90", pull90, 1'b0);
    chk("sda out", sda_o, 1'b0);
    chk("scl out", scl_o, 1'b0);
    for (int k = 0; k < 16; k++)
    begin
      code = 4'(k);
      if (code != 4'hb)
      begin
        @(posedge clk) #1 strap = code[1:0];
        ok = code inside {0, 2, 4, 8, 9, 10, 12, 13, 14, 15};
        c0 = convs;
        s0 = strobes;
        wr({code, code[1:0], code[0], 1'b1});
        chk("addr ack", aa, 1'b1);
        chk("cmd ack", ac, ok);
        chk("acquire", acq, ok);
        if (k == 0)
        begin
          tac_host_model_i.send_byte(8'h01, ac);
          chk("extra ack", ac, 1'b0);
        end
        stop_wait();
        chk("conv", 12'(convs - c0), ok);
        chk("strobe", 12'(strobes - s0), ok);
        if (ok)
        begin
          fe = code;
          pe = code[1:0];
          re = code[0];
        end
        chk("fsel", fsel, fe);
        chk("pmode", pmode, pe);
        chk("res8", res8, re);
      end
    end
    tac_host_model_i.start();
    tac_host_model_i.send_byte({5'h12, ~strap, 1'b0}, aa);
    chk("wrong addr", aa, 1'b0);
    stop_wait();
    for (int k = 0; k < 4; k++)
    begin
      wr({4'hb, 2'h0, k[1:0]});
      chk("setup ack", ac, 1'b0);
      stop_wait();
      chk("bypass", bypass, k[1]);
      chk("pull90", pull90, k[0]);
    end
    wr(8'hc0);
    stop_wait();
    chk("fsel", fsel, 4'hc);
    chk("bypass", bypass, 1'b1);
    chk("pull90", pull90, 1'b1);
    rd();
    stop_wait();
    chk("rd ack", aa, 1'b1);
    chk("byte0", b0, 8'ha5);
    chk("byte1", b1, 8'hc0);
    chk("byte2", b2, 8'hff);
    chk("fs stretch", stretched, 1'b0);
    @(posedge clk) #1 result = 12'h3c7;
    clen = 150;
    tac_host_model_i.start();
    tac_host_model_i.send_byte(8'h09, aa);
    chk("mcode ack", aa, 1'b0);
    wr(8'hc4);
    chk("hs mode", hs, 1'b1);
    chk("hs cmd ack", ac, 1'b1);
    rd();
    chk("hs kept", hs, 1'b1);
    chk("hs byte0", b0, 8'h3c);
    chk("hs byte1", b1, 8'h70);
    chk("hs stretch", stretched, 1'b1);
    stop_wait();
    chk("hs left", hs, 1'b0);
    finish_test();
  end
endmodule
